// *** common/aprp_pkg.sv ***
// package for the parallel read port host controller
package aprp_pkg;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  // control register offsets (8-bit address space)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_REGCMD = 8'h0c;
  localparam logic [7:0] ADDR_REGRES = 8'h10;
  // ctrl register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_REGRD = 1;
  localparam int CTRL_REGWR = 2;
  localparam int CTRL_JOINED = 3;
  localparam int CTRL_SWMODE = 4;
  // register frame layout
  localparam int FR_RW = 15;
  localparam int FR_ADDR_LO = 8;
  localparam logic FR_READ = 1'b1;
  localparam logic FR_WRITE = 1'b0;
  localparam logic [6:0] ADDR_EXIT_REG = 7'h00;
  // strobe timing in ns and cycles at 100 MHz
  localparam int CLK_NS = 10;
  localparam int STROBE_LOW_NS = 30;
  localparam int STROBE_HIGH_NS = 30;
  localparam int LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_LOW, ST_HIGH, ST_WLOW, ST_WHIGH
  } aprp_state_type;
  typedef struct packed {
    logic first;
    logic [CH_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } aprp_word_type;
endpackage

// *** core/aprp_host.sv ***
// host controller reading conversions over the parallel port
//
// How it works
// - software mode registers use chip select, read and write strobes.
// - low byte data, next seven bits address, top bit read/write select.
// - host may keep chip select low and toggle only read strobe.
// - fresh results are read only after busy falls.
// - with joined strobes each fall enables drivers and outputs next word.
// - host never reads across busy falling edge.
// - register read is a command frame then a returned data frame.
// - register write is one frame latched on write strobe rise.
`timescale 1ns/100ps
`default_nettype none
module aprp_host
  import aprp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic BUSY,
  input wire logic FIRST_FLAG,
  input wire logic [DATA_W-1:0] DB_IN,
  output logic [DATA_W-1:0] DB_OUT,
  output logic DB_OE,
  output logic CS_B,
  output logic RD_B,
  output logic WR_B,
  output logic INTERFACE_SELECT,
  output logic [2:0] OS_PINS,
  output logic SW_MODE,
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic [DATA_W+CH_W:0] WORD_DATA
);
  aprp_state_type state;
  logic [CNT_W-1:0] cnt;
  logic [CH_W-1:0] chan;
  logic [CH_W-1:0] seq_chan;
  logic joined;
  logic busy_q;
  logic pending;
  logic is_reg;
  logic reg_rd_phase;
  logic [DATA_W-1:0] reg_cmd;
  logic [DATA_W-1:0] reg_res;
  logic first_err;
  aprp_word_type buf_q [2];
  logic [1:0] buf_cnt;
  logic buf_wr;
  logic buf_rd;
  logic buf_ready;
  logic busy_fall;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // ------------------------------------------------------------
  // pin configuration
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      INTERFACE_SELECT <= 1'b1;
      OS_PINS <= 3'h0;
    end else begin
      INTERFACE_SELECT <= 1'b0;
      OS_PINS <= {3{SW_MODE}};
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  assign busy_fall = busy_q && !BUSY;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      busy_q <= 1'b0;
      pending <= 1'b0;
      joined <= 1'b0;
      SW_MODE <= 1'b0;
      is_reg <= 1'b0;
      reg_cmd <= 16'h0000;
    end else begin
      busy_q <= BUSY;
      if (WR && ADDR == ADDR_CTRL && state == ST_IDLE) begin
        joined <= WDATA[CTRL_JOINED];
        SW_MODE <= WDATA[CTRL_SWMODE];
        pending <= WDATA[CTRL_START];
        is_reg <= WDATA[CTRL_REGRD] | WDATA[CTRL_REGWR];
      end else if (state == ST_IDLE && is_reg) begin
        pending <= 1'b0;
      end else if (state == ST_WAIT && !BUSY && !busy_fall) begin
        pending <= 1'b0;
      end
      if (WR && ADDR == ADDR_REGCMD)
        reg_cmd <= WDATA[DATA_W-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      unique case (ADDR)
        ADDR_STATUS: RDATA <= {26'h0, first_err, buf_cnt, BUSY,
                               pending, state != ST_IDLE};
        ADDR_DATA: RDATA <= {12'h0, buf_q[0]};
        ADDR_REGRES: RDATA <= {16'h0, reg_res};
        ADDR_CTRL: RDATA <= {27'h0, SW_MODE, joined, 3'h0};
        default: RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // strobe sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      chan <= 3'h0;
      CS_B <= 1'b1;
      RD_B <= 1'b1;
      WR_B <= 1'b1;
      DB_OE <= 1'b0;
      DB_OUT <= 16'h0000;
      reg_rd_phase <= 1'b0;
      reg_res <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          CS_B <= 1'b1;
          if (pending && is_reg) begin
            state <= ST_WLOW;
            CS_B <= 1'b0;
            WR_B <= 1'b0;
            DB_OE <= 1'b1;
            DB_OUT <= reg_cmd;
            reg_rd_phase <= reg_cmd[FR_RW] == FR_READ;
            cnt <= cyc(LOW_CYC);
          end else if (pending) begin
            state <= ST_WAIT;
            chan <= 3'h0;
          end
        end
        ST_WAIT: begin
          if (!BUSY && !busy_fall) begin
            state <= ST_LOW;
            CS_B <= 1'b0;
            RD_B <= 1'b0;
            cnt <= cyc(LOW_CYC);
          end
        end
        ST_LOW: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (buf_ready || reg_rd_phase) begin
            RD_B <= 1'b1;
            if (joined || reg_rd_phase)
              CS_B <= 1'b1;
            if (reg_rd_phase)
              reg_res <= DB_IN;
            cnt <= cyc(HIGH_CYC);
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (reg_rd_phase || chan == CH_W'(NUM_CH - 1)) begin
            reg_rd_phase <= 1'b0;
            CS_B <= 1'b1;
            state <= ST_IDLE;
          end else begin
            chan <= chan + 3'h1;
            CS_B <= 1'b0;
            RD_B <= 1'b0;
            cnt <= cyc(LOW_CYC);
            state <= ST_LOW;
          end
        end
        ST_WLOW: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            WR_B <= 1'b1;
            CS_B <= 1'b1;
            cnt <= cyc(HIGH_CYC);
            state <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          DB_OE <= 1'b0;
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (reg_rd_phase) begin
            CS_B <= 1'b0;
            RD_B <= 1'b0;
            cnt <= cyc(LOW_CYC);
            state <= ST_LOW;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // two-entry result buffer
  // ------------------------------------------------------------
  assign buf_ready = buf_cnt != 2'd2;
  assign buf_wr = state == ST_LOW && cnt == 4'h0 && buf_ready
                  && !reg_rd_phase;
  assign buf_rd = WORD_VALID && WORD_READY;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      buf_cnt <= 2'd0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      first_err <= 1'b0;
    end else begin
      if (buf_wr && (FIRST_FLAG != (chan == 3'h0)))
        first_err <= 1'b1;
      if (buf_rd) begin
        buf_q[0] <= buf_q[1];
      end
      if (buf_wr) begin
        if (buf_cnt == 2'd0 || (buf_cnt == 2'd1 && buf_rd))
          buf_q[0] <= '{FIRST_FLAG, chan, DB_IN};
        else
          buf_q[1] <= '{FIRST_FLAG, chan, DB_IN};
      end
      buf_cnt <= buf_cnt + 2'(buf_wr) - 2'(buf_rd);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      WORD_VALID <= 1'b0;
      WORD_DATA <= '0;
    end else begin
      WORD_VALID <= (buf_cnt - 2'(buf_rd) + 2'(buf_wr)) != 2'd0;
      WORD_DATA <= (buf_rd || buf_cnt == 2'd0) ?
                   (buf_cnt == 2'd2 ? buf_q[1] :
                    aprp_word_type'{FIRST_FLAG, chan, DB_IN})
                   : buf_q[0];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // channel that the next buffered word must carry
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      seq_chan <= 3'h0;
    end else if (state == ST_WAIT) begin
      seq_chan <= 3'h0;
    end else if (buf_wr) begin
      seq_chan <= seq_chan + 3'h1;
    end
  end

  chk_fresh_read: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(RD_B) && state == ST_LOW && !reg_rd_phase |-> !BUSY)
    else $error("read strobe while busy");
  chk_cfg_pins: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state != ST_IDLE |-> !INTERFACE_SELECT)
    else $error("interface not parallel");
  chk_write_rise: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $rose(WR_B) |-> DB_OE)
    else $error("write data dropped at strobe rise");
  chk_chan_order: assert property (@(posedge CLOCK) disable iff (!RST_B)
    buf_wr |-> chan == seq_chan)
    else $error("channel order broken");
  chk_idle_release: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state == ST_IDLE |-> CS_B)
    else $error("chip select low while idle");
  chk_bus_turn: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !RD_B |-> !DB_OE)
    else $error("host drives bus during read");
  chk_strobe_excl: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !(!RD_B && !WR_B))
    else $error("both strobes low");
  cov_adc: cover property (@(posedge CLOCK) buf_wr && chan == 3'h7);
  cov_reg: cover property (@(posedge CLOCK) $rose(WR_B) && reg_rd_phase);
  cov_stall: cover property (@(posedge CLOCK) buf_cnt == 2'd2);
endmodule
`default_nettype wire

// *** tb/aprp_dev_model.sv ***
// behavioural converter on the far side of the parallel port
`timescale 1ns/100ps
`default_nettype none
module aprp_dev_model
  import aprp_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic sel,
  input wire logic [2:0] os,
  input wire logic cs_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [DATA_W-1:0] host_db,
  output logic [DATA_W-1:0] db,
  output logic flag,
  output logic busy = 1'b0
);
  logic [7:0] regs [128];
  logic [DATA_W-1:0] word = 16'h0000;
  logic [6:0] raddr = 7'h00;
  logic [7:0] conv = 8'h00;
  logic [4:0] bcnt = 5'h00;
  logic [CH_W-1:0] ch = '0;
  logic reg_mode = 1'b0;
  logic first = 1'b0;
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      bcnt <= 5'h14;
    end else if (bcnt == 5'h01) begin
      busy <= 1'b0;
      conv <= conv + 8'h01;
      ch <= '0;
      bcnt <= 5'h00;
    end else if (bcnt != 5'h00) begin
      bcnt <= bcnt - 5'h01;
    end
  end
  always @(negedge rd_b) begin
    #1;
    if (!cs_b && reg_mode) begin
      word = {1'b0, raddr, regs[raddr]};
    end else if (!cs_b) begin
      word = {conv, 5'h00, ch};
      first = (ch == '0);
      ch = ch + 1'b1;
    end
  end
  always @(posedge wr_b) begin
    if (os == 3'b111) begin
      if (host_db[15]) begin
        reg_mode = 1'b1;
        raddr = host_db[14:8];
      end else begin
        regs[host_db[14:8]] = host_db[7:0];
        if (host_db[14:8] == 7'h00)
          reg_mode = 1'b0;
      end
    end
  end
  assign db = (!cs_b && !sel) ? word : ~word;
  assign flag = (!cs_b && !sel) ? first : ~first;
endmodule
`default_nettype wire

// *** tb/aprp_host_test.sv ***
// self-checking bench for the parallel read port host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module aprp_host_test
  import aprp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic word_ready = 1'b0;
  logic [31:0] rdata;
  logic [DATA_W-1:0] db_out, dev_db, db_in;
  logic db_oe, cs_b, rd_b, wr_b, if_sel, sw_mode, word_valid, busy, flag;
  logic [2:0] os_pins;
  logic [DATA_W+CH_W:0] word_data;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] s;
  logic [7:0] v;
  assign db_in = db_oe ? db_out : dev_db;
  aprp_host i_dut (.CLOCK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy), .FIRST_FLAG(flag),
    .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .CS_B(cs_b), .RD_B(rd_b),
    .WR_B(wr_b), .INTERFACE_SELECT(if_sel), .OS_PINS(os_pins),
    .SW_MODE(sw_mode), .WORD_VALID(word_valid), .WORD_READY(word_ready),
    .WORD_DATA(word_data));
  aprp_dev_model i_dev (.clk(clk), .go(go), .sel(if_sel), .os(os_pins),
    .cs_b(cs_b), .rd_b(rd_b),
    .wr_b(wr_b), .host_db(db_out), .db(dev_db), .flag(flag), .busy(busy));
  always #5 clk = ~clk;
  // ----------------
  // bus tasks
  // ----------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle;
    logic [31:0] st;
    st = 32'h3;
    for (int i = 0; i < 300 && st[1:0] != 2'b00; i++)
      rd_reg(ADDR_STATUS, st);
  endtask
  function automatic logic [DATA_W+CH_W:0] exp_word(input logic [7:0] k,
      input logic [2:0] c);
    return {(c == 3'h0), c, k, 5'h00, c};
  endfunction
  task automatic take_frame(input logic [7:0] k);
    int n;
    n = 0;
    for (int i = 0; i < 3000 && n < NUM_CH; i++) begin
      @(posedge clk);
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
        `CHK(word_data, exp_word(k, n[2:0]))
        n++;
      end
      word_ready <= ($urandom % 3) != 0;
    end
    @(posedge clk);
    word_ready <= 1'b0;
    `CHK(n, NUM_CH)
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'h6601d6d1));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 `CHK(if_sel, 1'b0)
    for (int k = 1; k <= 4; k++) begin
      if (k == 4) begin
        v = 8'($urandom);
        wr_reg(ADDR_REGCMD, {16'h0, FR_WRITE, 7'h05, v});
        wr_reg(ADDR_CTRL, 32'h15);
        wait_idle;
        `CHK(os_pins, 3'b111)
        `CHK(sw_mode, 1'b1)
        wr_reg(ADDR_REGCMD, {16'h0, FR_READ, 7'h05, 8'h00});
        wr_reg(ADDR_CTRL, 32'h13);
        wait_idle;
        rd_reg(ADDR_REGRES, s);
        `CHK(s[15:0], {FR_WRITE, 7'h05, v})
        wr_reg(ADDR_REGCMD, {16'h0, FR_WRITE, ADDR_EXIT_REG, 8'h00});
        wr_reg(ADDR_CTRL, 32'h15);
        wait_idle;
      end
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      // first frame is started while busy, so the controller must wait
      for (int i = 0; i < 100 && k != 1 && busy !== 1'b0; i++)
        @(posedge clk);
      wr_reg(ADDR_CTRL, k == 2 ? 32'h9 : 32'h1);
      if (k == 3) begin
        repeat (60) @(posedge clk);
        rd_reg(ADDR_STATUS, s);
        `CHK(s[4:3], 2'b10)
      end
      take_frame(k[7:0]);
      wait_idle;
    end
    rd_reg(ADDR_STATUS, s);
    `CHK(s[5], 1'b0)
    rd_reg(8'h20, s);
    `CHK(s, 32'h0)
    end_sim;
  end
endmodule
`default_nettype wire
